// file: hw/qfd_top.sv
// quadrature encoder input filters, decoder and position counter with ahb-lite registers
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - a filtered channel changes only after three equal samples on successive filter clock ticks.
// - spikes between filter ticks are unseen and pulses under two filter periods are rejected.
// - the filter tick is the core clock divided by a 3-bit field at filter control bits 6:4, shared by all channels.
// - filter control bit 7 routes phase a, phase b and index through their filters.
// - decode mode 001 counts on both edges of both phases.
// - decode mode 000 counts only on phase a edges, phase b still gives direction.
// - a rise after b fall, a fall after b rise, b rise after a rise, b fall after a fall set direction and count up.
// - a rise after b rise, a fall after b fall, b rise after a fall, b fall after a rise clear direction and count down.
// - an edge following the opposite edge of the same phase toggles direction and counts one step.
// - encoder control bit 6 with the pin set as output lets the direction flag drive the pin.
// - the direction flag reads at encoder control bit 11 and ignores writes.
// - with swap clear phase a feeds decoder a and phase b feeds decoder b.
// - with swap set the phases are exchanged at the decoder.
// - the 16-bit position counter steps by one per count pulse in the decoded direction.
module qfd_top (
  input wire logic core_clk, // 10 MHz core clock
  input wire logic rst_n, // async reset, active low
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  input wire logic phase_a_in, // encoder phase a pin
  input wire logic phase_b_in, // encoder phase b pin
  input wire logic index_in, // encoder index pin
  input wire logic pin_dir_ctrl, // pin direction, low means output
  output logic count_dir_o, // direction pin output value
  output logic count_dir_oe_n // direction pin output enable, low drives
);
  logic [10:0] filter_ctrl_reg;
  logic [12:0] encoder_ctrl_reg;
  logic [15:0] position_count;
  logic count_dir;
  logic filter_enable;
  logic [2:0] filter_clk_div_sel;
  logic [2:0] decode_mode_sel;
  logic phase_swap;
  logic dir_pin_out_en;
  assign filter_enable = filter_ctrl_reg[qfd_pkg::FILT_EN_BIT];
  assign filter_clk_div_sel = filter_ctrl_reg[qfd_pkg::FILT_DIV_LSB +: 3];
  assign decode_mode_sel = encoder_ctrl_reg[qfd_pkg::MODE_LSB +: 3];
  assign phase_swap = encoder_ctrl_reg[qfd_pkg::SWAP_BIT];
  assign dir_pin_out_en = encoder_ctrl_reg[qfd_pkg::DIR_OE_BIT];

  // two-flop synchronisers; stage one is read only by stage two
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {index_in, phase_b_in, phase_a_in};
      sync2_r <= sync1_r;
    end
  end

  logic [7:0] div_cnt_r;
  logic [7:0] div_top;
  logic filt_tick;
  // code to terminal count; the ratios skip divide by eight between codes 2 and 3
  function automatic logic [7:0] div_top_of(input logic [2:0] code);
    logic [7:0] t;
    t = qfd_pkg::DIV_TOP_C0;
    case (code)
      3'h1: t = qfd_pkg::DIV_TOP_C1;
      3'h2: t = qfd_pkg::DIV_TOP_C2;
      3'h3: t = qfd_pkg::DIV_TOP_C3;
      3'h4: t = qfd_pkg::DIV_TOP_C4;
      3'h5: t = qfd_pkg::DIV_TOP_C5;
      3'h6: t = qfd_pkg::DIV_TOP_C6;
      3'h7: t = qfd_pkg::DIV_TOP_C7;
      default: t = qfd_pkg::DIV_TOP_C0;
    endcase
    return t;
  endfunction : div_top_of
  assign div_top = div_top_of(filter_clk_div_sel);
  assign filt_tick = (div_cnt_r >= div_top);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= qfd_pkg::DIV_CNT_RST;
    end else if (filt_tick) begin
      div_cnt_r <= qfd_pkg::DIV_CNT_RST;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  // three-sample filter per channel, sampled only on ticks
  logic [2:0] filt_r;
  logic [2:0] chan;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filt
      logic [1:0] hist_r;
      logic filt_bit_r;
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          hist_r <= 2'h0;
          filt_bit_r <= 1'b0;
        end else if (filt_tick) begin
          hist_r <= {hist_r[0], sync2_r[gi]};
          if (hist_r[1] == hist_r[0] && hist_r[0] == sync2_r[gi]) begin
            filt_bit_r <= sync2_r[gi];
          end
        end
      end
      assign filt_r[gi] = filt_bit_r;
      assign chan[gi] = filter_enable ? filt_r[gi] : sync2_r[gi];
    end
  endgenerate

  logic dec_a;
  logic dec_b;
  assign dec_a = phase_swap ? chan[1] : chan[0];
  assign dec_b = phase_swap ? chan[0] : chan[1];

  logic a_prev_r;
  logic b_prev_r;
  qfd_pkg::qfd_edge_t last_edge_r;
  logic edge_seen_r;
  logic ev_valid;
  qfd_pkg::qfd_edge_t ev;
  always_comb begin
    ev_valid = 1'b1;
    ev = qfd_pkg::QFD_EV_AR;
    if (dec_a != a_prev_r) begin
      ev = dec_a ? qfd_pkg::QFD_EV_AR : qfd_pkg::QFD_EV_AF;
    end else if (dec_b != b_prev_r) begin
      ev = dec_b ? qfd_pkg::QFD_EV_BR : qfd_pkg::QFD_EV_BF;
    end else begin
      ev_valid = 1'b0;
    end
  end

  // lead/lag test; returns {toggle, up}
  function automatic logic [1:0] lead_lag(input qfd_pkg::qfd_edge_t cur, input qfd_pkg::qfd_edge_t prev);
    logic [1:0] r;
    r = 2'b00;
    if (cur[1] == prev[1]) begin
      r = 2'b10;
    end else begin
      case (cur)
        qfd_pkg::QFD_EV_AR: r = {1'b0, prev == qfd_pkg::QFD_EV_BF};
        qfd_pkg::QFD_EV_AF: r = {1'b0, prev == qfd_pkg::QFD_EV_BR};
        qfd_pkg::QFD_EV_BR: r = {1'b0, prev == qfd_pkg::QFD_EV_AR};
        default: r = {1'b0, prev == qfd_pkg::QFD_EV_AF};
      endcase
    end
    return r;
  endfunction : lead_lag

  logic [1:0] ll;
  logic dir_nxt;
  logic count_pulse;
  assign ll = lead_lag(ev, last_edge_r);
  assign dir_nxt = !edge_seen_r ? count_dir : (ll[1] ? !count_dir : ll[0]);
  // x4 counts all edges, x2 only phase a edges
  assign count_pulse = ev_valid && edge_seen_r && (decode_mode_sel == qfd_pkg::MODE_X4 || ev[1] == 1'b0);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
      last_edge_r <= qfd_pkg::QFD_EV_AR;
      edge_seen_r <= 1'b0;
      count_dir <= 1'b0;
    end else begin
      // a simultaneous b change is caught next cycle since b_prev only follows in cycles without an a edge
      a_prev_r <= dec_a;
      if (dec_a == a_prev_r) begin
        b_prev_r <= dec_b;
      end
      if (ev_valid) begin
        last_edge_r <= ev;
        edge_seen_r <= 1'b1;
        count_dir <= dir_nxt;
      end
    end
  end

  // ahb-lite slave, zero wait state
  logic wr_pend_r;
  logic [31:0] addr_r;
  logic take;
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      addr_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= take && hwrite;
      if (take) begin
        addr_r <= haddr;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_ctrl_reg <= qfd_pkg::FILT_CTRL_RST;
      encoder_ctrl_reg <= qfd_pkg::ENC_CTRL_RST;
    end else if (wr_pend_r) begin
      if (addr_r[7:0] == qfd_pkg::FILT_CTRL_OFS[7:0]) begin
        filter_ctrl_reg <= {3'h0, hwdata[7:0]} & 11'h0F0;
      end else if (addr_r[7:0] == qfd_pkg::ENC_CTRL_OFS[7:0]) begin
        encoder_ctrl_reg <= {2'h0, hwdata[10:6], 6'h00};
      end
    end
  end

  // position counter, software write wins over a count pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      position_count <= qfd_pkg::POS_RST;
    end else if (wr_pend_r && addr_r[7:0] == qfd_pkg::POS_COUNT_OFS[7:0]) begin
      position_count <= hwdata[15:0];
    end else if (count_pulse) begin
      position_count <= dir_nxt ? position_count + 16'h0001 : position_count - 16'h0001;
    end
  end

  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (haddr[7:0] == qfd_pkg::FILT_CTRL_OFS[7:0]) begin
      rd_nxt = {21'h0, filter_ctrl_reg};
    end else if (haddr[7:0] == qfd_pkg::ENC_CTRL_OFS[7:0]) begin
      rd_nxt = {19'h0, encoder_ctrl_reg};
      rd_nxt[qfd_pkg::DIR_BIT] = count_dir;
      rd_nxt[qfd_pkg::INDEX_BIT] = chan[2];
    end else if (haddr[7:0] == qfd_pkg::POS_COUNT_OFS[7:0]) begin
      rd_nxt = {16'h0, position_count};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      count_dir_o <= 1'b0;
      count_dir_oe_n <= 1'b1;
    end else begin
      if (take && !hwrite) begin
        hrdata <= rd_nxt;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      count_dir_o <= count_dir;
      count_dir_oe_n <= !(dir_pin_out_en && !pin_dir_ctrl);
    end
  end

  property p_pos_step;
    @(posedge core_clk) disable iff (!rst_n)
    (count_pulse && !wr_pend_r) |=> (position_count == $past(position_count) + 16'h0001)
      || (position_count == $past(position_count) - 16'h0001);
  endproperty
  a_pos_step: assert property (p_pos_step) else $error("position did not step by one");
  property p_x2_no_b;
    @(posedge core_clk) disable iff (!rst_n)
    (decode_mode_sel == qfd_pkg::MODE_X2 && ev_valid && ev[1]) |-> !count_pulse;
  endproperty
  a_x2_no_b: assert property (p_x2_no_b) else $error("x2 counted on b edge");
  property p_x4;
    @(posedge core_clk) disable iff (!rst_n)
    (decode_mode_sel == qfd_pkg::MODE_X4 && ev_valid && edge_seen_r) |-> count_pulse;
  endproperty
  a_x4: assert property (p_x4) else $error("x4 missed an edge");
  property p_up;
    @(posedge core_clk) disable iff (!rst_n)
    (ev_valid && edge_seen_r && ev == qfd_pkg::QFD_EV_AR && last_edge_r == qfd_pkg::QFD_EV_BF) |=> count_dir;
  endproperty
  a_up: assert property (p_up) else $error("a rise after b fall not up");
  property p_down;
    @(posedge core_clk) disable iff (!rst_n)
    (ev_valid && edge_seen_r && ev == qfd_pkg::QFD_EV_AR && last_edge_r == qfd_pkg::QFD_EV_BR) |=> !count_dir;
  endproperty
  a_down: assert property (p_down) else $error("a rise after b rise not down");
  property p_toggle;
    @(posedge core_clk) disable iff (!rst_n)
    (ev_valid && edge_seen_r && ev == qfd_pkg::QFD_EV_AR && last_edge_r == qfd_pkg::QFD_EV_AF)
      |=> count_dir != $past(count_dir);
  endproperty
  a_toggle: assert property (p_toggle) else $error("reversal did not toggle");
  property p_filt_hold;
    @(posedge core_clk) disable iff (!rst_n)
    !(filt_tick && g_filt[0].hist_r == {2{sync2_r[0]}}) |=> filt_r[0] == $past(filt_r[0]);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter changed without agreement");
  property p_filt_agree;
    @(posedge core_clk) disable iff (!rst_n)
    (filt_tick && g_filt[0].hist_r == {2{sync2_r[0]}}) |=> filt_r[0] == $past(sync2_r[0]);
  endproperty
  a_filt_agree: assert property (p_filt_agree) else $error("filter missed three equal samples");
  property p_tick_top;
    @(posedge core_clk) disable iff (!rst_n)
    (filt_tick && $stable(filter_clk_div_sel)) |-> div_cnt_r == div_top;
  endproperty
  a_tick_top: assert property (p_tick_top) else $error("filter tick off its terminal count");
  property p_div_256;
    @(posedge core_clk) disable iff (!rst_n)
    (filter_clk_div_sel == 3'h7) |-> div_top == 8'hFF;
  endproperty
  a_div_256: assert property (p_div_256) else $error("top code not divide by 256");
  property p_filt_route;
    @(posedge core_clk) disable iff (!rst_n)
    filter_enable |-> chan == filt_r;
  endproperty
  a_filt_route: assert property (p_filt_route) else $error("filtered path not taken");
  property p_dir_ro;
    @(posedge core_clk) disable iff (!rst_n)
    !ev_valid |=> $stable(count_dir);
  endproperty
  a_dir_ro: assert property (p_dir_ro) else $error("direction changed without an edge");
  property p_dir_out;
    @(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> count_dir_o == $past(count_dir);
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("direction pin does not follow flag");
  property p_dir_pin_off;
    @(posedge core_clk) disable iff (!rst_n)
    !(dir_pin_out_en && !pin_dir_ctrl) |=> count_dir_oe_n;
  endproperty
  a_dir_pin_off: assert property (p_dir_pin_off) else $error("direction pin driven while disabled");
  property p_bypass;
    @(posedge core_clk) disable iff (!rst_n)
    !filter_enable |-> chan == sync2_r;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not taken");
  property p_dir_pin;
    @(posedge core_clk) disable iff (!rst_n)
    (dir_pin_out_en && !pin_dir_ctrl) |=> !count_dir_oe_n;
  endproperty
  a_dir_pin: assert property (p_dir_pin) else $error("direction pin not driven");
  c_up: cover property (@(posedge core_clk) disable iff (!rst_n) count_pulse && dir_nxt);
  c_down: cover property (@(posedge core_clk) disable iff (!rst_n) count_pulse && !dir_nxt);
  c_swap: cover property (@(posedge core_clk) disable iff (!rst_n) count_pulse && phase_swap);
endmodule : qfd_top
`default_nettype wire

// file: hw/qfd_pkg.sv
// package of constants for the quadrature filter decoder
package qfd_pkg;
  localparam logic [31:0] FILT_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] ENC_CTRL_OFS = 32'h0000_0004;
  localparam logic [31:0] POS_COUNT_OFS = 32'h0000_0008;
  localparam int FILT_EN_BIT = 7;
  localparam int FILT_DIV_LSB = 4;
  localparam int MODE_LSB = 8;
  localparam int DIR_BIT = 11;
  localparam int DIR_OE_BIT = 6;
  localparam int SWAP_BIT = 7;
  localparam int INDEX_BIT = 12;
  localparam int FILT_STABLE_CNT = 3;
  localparam logic [2:0] MODE_X2 = 3'h0;
  localparam logic [2:0] MODE_X4 = 3'h1;
  localparam logic [7:0] DIV_CNT_RST = 8'h00;
  localparam logic [7:0] DIV_TOP_C0 = 8'h00;
  localparam logic [7:0] DIV_TOP_C1 = 8'h01;
  localparam logic [7:0] DIV_TOP_C2 = 8'h03;
  localparam logic [7:0] DIV_TOP_C3 = 8'h0F;
  localparam logic [7:0] DIV_TOP_C4 = 8'h1F;
  localparam logic [7:0] DIV_TOP_C5 = 8'h3F;
  localparam logic [7:0] DIV_TOP_C6 = 8'h7F;
  localparam logic [7:0] DIV_TOP_C7 = 8'hFF;
  localparam logic [15:0] POS_RST = 16'h0000;
  localparam logic [10:0] FILT_CTRL_RST = 11'h000;
  localparam logic [12:0] ENC_CTRL_RST = 13'h0000;
  typedef enum logic [1:0] {
    QFD_EV_AR = 2'b00,
    QFD_EV_AF = 2'b01,
    QFD_EV_BR = 2'b10,
    QFD_EV_BF = 2'b11
  } qfd_edge_t;
endpackage : qfd_pkg

// file: sim/qfd_encoder_model.sv
// behavioural incremental encoder driving phase and index lines
`timescale 1ns/1ps
`default_nettype none
module qfd_encoder_model (
  input wire logic core_clk, // pacing clock
  output logic phase_a, // phase a line
  output logic phase_b, // phase b line
  output logic index // index line
);
  logic [1:0] st;
  initial begin
    st = 2'h0;
    phase_a = 1'b0;
    phase_b = 1'b0;
    index = 1'b0;
  end
  // gray order 00,10,11,01 so that a leads b when moving forward
  task automatic step(input logic fwd, input int hold);
    @(posedge core_clk);
    st = fwd ? st + 2'h1 : st - 2'h1;
    phase_a <= st[0] ^ st[1];
    phase_b <= st[1];
    repeat (hold) @(posedge core_clk);
  endtask : step
  // short spike on phase a, returned to its level afterwards
  task automatic glitch(input int w);
    @(posedge core_clk);
    phase_a <= ~phase_a;
    repeat (w) @(posedge core_clk);
    phase_a <= ~phase_a;
    repeat (40) @(posedge core_clk);
  endtask : glitch
  task automatic set_index(input logic v, input int hold);
    @(posedge core_clk);
    index <= v;
    repeat (hold) @(posedge core_clk);
  endtask : set_index
endmodule : qfd_encoder_model
`default_nettype wire

// file: sim/qfd_top_bench.sv
// self-checking bench: ahb-lite register access and encoder stimulus
`timescale 1ns/1ps
`default_nettype none
module qfd_top_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic pin_dir_ctrl = 1'b1;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic count_dir_o;
  logic count_dir_oe_n;
  wire logic phase_a;
  wire logic phase_b;
  wire logic index;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  always #50 core_clk = ~core_clk;
  qfd_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .phase_a_in(phase_a), .phase_b_in(phase_b), .index_in(index),
    .pin_dir_ctrl(pin_dir_ctrl), .count_dir_o(count_dir_o), .count_dir_oe_n(count_dir_oe_n));
  qfd_encoder_model i_enc (.core_clk(core_clk), .phase_a(phase_a), .phase_b(phase_b), .index(index));
  task automatic finish_test;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one single transfer; waits on hready at both phases, no fixed latency assumed
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask : rd
  task automatic steps(input logic fwd, input int n, input int hold);
    repeat (n) i_enc.step(fwd, hold);
  endtask : steps
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(qfd_pkg::FILT_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(qfd_pkg::ENC_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(qfd_pkg::POS_COUNT_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(32'h0000_0010, 32'hFFFF_FFFF, 32'h0000_0000);
    pin_dir_ctrl <= 1'b0;
    wr(qfd_pkg::ENC_CTRL_OFS, 32'h0000_0140);
    // first edge after reset only primes the edge history
    i_enc.step(1'b1, 8);
    wr(qfd_pkg::POS_COUNT_OFS, 32'h0000_0000);
    steps(1'b1, 4, 8);
    rd(qfd_pkg::POS_COUNT_OFS, 32'hFFFF_FFFF, 32'h0000_0004);
    wr(qfd_pkg::ENC_CTRL_OFS, 32'h0000_0140);
    rd(qfd_pkg::ENC_CTRL_OFS, 32'h0000_0800, 32'h0000_0800);
    chk({30'h0, count_dir_o, count_dir_oe_n}, 32'h0000_0002);
    steps(1'b0, 2, 8);
    rd(qfd_pkg::POS_COUNT_OFS, 32'hFFFF_FFFF, 32'h0000_0002);
    chk({30'h0, count_dir_o, count_dir_oe_n}, 32'h0000_0000);
    pin_dir_ctrl <= 1'b1;
    wr(qfd_pkg::POS_COUNT_OFS, 32'h0000_FFFF);
    chk({31'h0, count_dir_oe_n}, 32'h0000_0001);
    i_enc.step(1'b1, 8);
    rd(qfd_pkg::POS_COUNT_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(qfd_pkg::ENC_CTRL_OFS, 32'h0000_0000);
    steps(1'b1, 4, 8);
    rd(qfd_pkg::POS_COUNT_OFS, 32'hFFFF_FFFF, 32'h0000_0002);
    wr(qfd_pkg::ENC_CTRL_OFS, 32'h0000_0180);
    steps(1'b1, 4, 8);
    rd(qfd_pkg::POS_COUNT_OFS, 32'hFFFF_FFFF, 32'h0000_FFFE);
    wr(qfd_pkg::ENC_CTRL_OFS, 32'h0000_0100);
    wr(qfd_pkg::FILT_CTRL_OFS, 32'h0000_0090);
    wr(qfd_pkg::POS_COUNT_OFS, 32'h0000_0000);
    // two core cycles is under two filter periods at divide by two
    i_enc.glitch(2);
    rd(qfd_pkg::POS_COUNT_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    i_enc.step(1'b1, 40);
    wr(qfd_pkg::POS_COUNT_OFS, 32'h0000_0000);
    i_enc.step(1'b1, 40);
    rd(qfd_pkg::POS_COUNT_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
    wr(qfd_pkg::FILT_CTRL_OFS, 32'h0000_00F0);
    // at divide by 256 three ticks take far longer than 100 cycles
    i_enc.step(1'b1, 100);
    rd(qfd_pkg::POS_COUNT_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
    repeat (900) @(posedge core_clk);
    rd(qfd_pkg::POS_COUNT_OFS, 32'hFFFF_FFFF, 32'h0000_0002);
    i_enc.set_index(1'b1, 1000);
    rd(qfd_pkg::ENC_CTRL_OFS, 32'h0000_1000, 32'h0000_1000);
    finish_test();
  end
endmodule : qfd_top_bench
`default_nettype wire
